// ===== src/i2c_slave_port.sv
// Notes on behaviour
// - Slave only; serial clock is input only.
// - Data line pulled low or released only.
// - Works at 100 and 400 kbps.
// - Answers fixed address 0101110, then direction.
// - Bytes shift eight bits, MSB first.
// - Receiver acknowledges in the ninth clock.
// - Master starts transfers and makes every clock.
// - Start/stop are data edges with clock high.
// - Data changes only while clock is low.
// - Receiving device pulls acknowledge low; transmitter releases.
// - Unacceptable byte gets not-acknowledge; master stops.
// - Registers take one byte; FIFOs take many.
// - Write: address, register byte, data, stop.
// - Further write bytes each acknowledged by a FIFO only.
// - Read: write address, repeated start, read.
// - Master acknowledges all but last read byte.
`timescale 1ns/1ns
`include "i2c_port_map.svh"
module i2c_slave_port (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic I_LINK_CLK,
    input wire logic I_ACCEPT,
    input wire logic [7:0] I_RDATA,
    output logic O_WR_STB,
    output logic O_RD_STB,
    output logic [7:0] O_ADDR,
    output logic [7:0] O_WDATA,
    i2c_link_if.dev LINK
);
    function automatic logic is_fifo(input logic [7:0] addr);
        is_fifo = addr[`I2C_FIFO_FLAG_BIT];
    endfunction

    // Link-domain state.
    logic rst_m, rst_l, ce_m, ce_l, acc_m, acc_l;
    logic [2:0] scl_s, sda_s;
    logic scl_f, sda_f, scl_p, sda_p;
    logic start, stop, rise, fall;
    i2c_port_pkg::dev_state_t state;
    i2c_port_pkg::byte_kind_t kind;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx_byte;
    logic rw;
    logic [7:0] reg_addr;
    logic first_data;
    logic ack_ok;
    logic sda_low;
    logic req_tgl, req_rd;
    logic [7:0] req_data;
    logic [2:0] ack_s;
    logic [7:0] rd_link;
    // Core-domain state.
    logic [2:0] req_s;
    logic req_edge;
    logic ack_tgl;
    logic [7:0] rd_core, rst_cnt;

    assign LINK.s_sda_o = 1'b0;
    assign LINK.s_sda_oe = sda_low;

    // Reset arrives stretched, since a short core pulse can fall between two link edges.
    always_ff @(posedge I_LINK_CLK) begin
        rst_m <= ~rst_cnt[`I2C_RST_STRETCH_BIT];
        rst_l <= rst_m;
        ce_m <= I_CE;
        ce_l <= ce_m;
        acc_m <= I_ACCEPT;
        acc_l <= acc_m;
    end

    // Both wires are pins: three stages, a change counts once the last two agree.
    always_ff @(posedge I_LINK_CLK) begin
        if (rst_l) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else if (ce_l) begin
            scl_s <= {scl_s[1:0], LINK.scl};
            sda_s <= {sda_s[1:0], LINK.sda};
            if (scl_s[1] == scl_s[2]) begin
                scl_f <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    assign start = scl_f & scl_p & sda_p & ~sda_f;
    assign stop = scl_f & scl_p & ~sda_p & sda_f;
    assign rise = scl_f & ~scl_p;
    assign fall = ~scl_f & scl_p;
    assign rx_byte = {sh[6:0], sda_f};

    always_ff @(posedge I_LINK_CLK) begin
        if (rst_l) begin
            state <= i2c_port_pkg::dev_idle;
            kind <= i2c_port_pkg::kind_dev;
            cnt <= 3'h0;
            sh <= `I2C_BYTE_RESET;
            rw <= `I2C_DIR_WRITE;
            reg_addr <= `I2C_BYTE_RESET;
            first_data <= 1'b0;
            ack_ok <= 1'b0;
            sda_low <= 1'b0;
            req_tgl <= 1'b0;
            req_rd <= 1'b0;
            req_data <= `I2C_BYTE_RESET;
        end else if (ce_l) begin
            if (stop) begin
                state <= i2c_port_pkg::dev_idle;
                sda_low <= 1'b0;
            end else if (start) begin
                state <= i2c_port_pkg::dev_recv;
                kind <= i2c_port_pkg::kind_dev;
                cnt <= 3'h0;
                sda_low <= 1'b0;
            end else begin
                case (state)
                    i2c_port_pkg::dev_recv: begin
                        if (rise) begin
                            sh <= rx_byte;
                            cnt <= cnt + 3'h1;
                            if (cnt == `I2C_LAST_BIT) begin
                                state <= i2c_port_pkg::dev_ackwait;
                                case (kind)
                                    i2c_port_pkg::kind_dev: begin
                                        ack_ok <= (rx_byte[7:1] == `I2C_DEV_ADDR);
                                        rw <= rx_byte[0];
                                        if (rx_byte[7:1] == `I2C_DEV_ADDR &&
                                            rx_byte[0] == `I2C_DIR_READ) begin
                                            req_tgl <= ~req_tgl;
                                            req_rd <= 1'b1;
                                        end
                                    end
                                    i2c_port_pkg::kind_reg: begin
                                        ack_ok <= 1'b1;
                                        reg_addr <= rx_byte;
                                        first_data <= 1'b1;
                                    end
                                    default: begin
                                        // A register takes one byte; a FIFO takes any number.
                                        if (acc_l && (first_data || is_fifo(reg_addr))) begin
                                            ack_ok <= 1'b1;
                                            req_tgl <= ~req_tgl;
                                            req_rd <= 1'b0;
                                            req_data <= rx_byte;
                                            first_data <= 1'b0;
                                        end else begin
                                            ack_ok <= 1'b0;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    i2c_port_pkg::dev_ackwait: begin
                        if (fall) begin
                            if (ack_ok) begin
                                sda_low <= 1'b1;
                                state <= i2c_port_pkg::dev_ackhold;
                            end else begin
                                state <= i2c_port_pkg::dev_idle;
                            end
                        end
                    end
                    i2c_port_pkg::dev_ackhold: begin
                        if (fall) begin
                            cnt <= 3'h0;
                            if (kind == i2c_port_pkg::kind_dev && rw == `I2C_DIR_READ) begin
                                state <= i2c_port_pkg::dev_tx;
                                sh <= rd_link;
                                sda_low <= ~rd_link[7];
                            end else begin
                                sda_low <= 1'b0;
                                state <= i2c_port_pkg::dev_recv;
                                kind <= (kind == i2c_port_pkg::kind_dev) ?
                                    i2c_port_pkg::kind_reg : i2c_port_pkg::kind_data;
                            end
                        end
                    end
                    i2c_port_pkg::dev_tx: begin
                        if (fall) begin
                            if (cnt == `I2C_LAST_BIT) begin
                                sda_low <= 1'b0;
                                state <= i2c_port_pkg::dev_txack;
                            end else begin
                                cnt <= cnt + 3'h1;
                                sh <= {sh[6:0], 1'b0};
                                sda_low <= ~sh[6];
                            end
                        end
                    end
                    i2c_port_pkg::dev_txack: begin
                        if (rise) begin
                            if (!sda_f) begin
                                // Same address again: a FIFO pops its next byte.
                                req_tgl <= ~req_tgl;
                                req_rd <= 1'b1;
                                state <= i2c_port_pkg::dev_txnext;
                            end else begin
                                state <= i2c_port_pkg::dev_idle;
                            end
                        end
                    end
                    i2c_port_pkg::dev_txnext: begin
                        if (fall) begin
                            state <= i2c_port_pkg::dev_tx;
                            cnt <= 3'h0;
                            sh <= rd_link;
                            sda_low <= ~rd_link[7];
                        end
                    end
                    default: begin
                        sda_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Read data returns with a toggle; the byte is stable in the core register by then.
    always_ff @(posedge I_LINK_CLK) begin
        if (rst_l) begin
            ack_s <= 3'h0;
            rd_link <= `I2C_RDATA_RESET;
        end else if (ce_l) begin
            ack_s <= {ack_s[1:0], ack_tgl};
            if (ack_s[2] != ack_s[1]) begin
                rd_link <= rd_core;
            end
        end
    end

    // Requests cross as a toggle; address and data stay put until the next byte.
    assign req_edge = (req_s[2] ^ req_s[1]) & rst_cnt[`I2C_RST_STRETCH_BIT];
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            rst_cnt <= 8'h00;
            req_s <= 3'h0;
            O_WR_STB <= 1'b0;
            O_RD_STB <= 1'b0;
            O_ADDR <= `I2C_BYTE_RESET;
            O_WDATA <= `I2C_BYTE_RESET;
            ack_tgl <= 1'b0;
            rd_core <= `I2C_RDATA_RESET;
        end else if (I_CE) begin
            rst_cnt <= rst_cnt + {7'h00, ~rst_cnt[`I2C_RST_STRETCH_BIT]};
            req_s <= {req_s[1:0], req_tgl};
            O_WR_STB <= req_edge & ~req_rd;
            O_RD_STB <= req_edge & req_rd;
            if (req_edge) begin
                O_ADDR <= reg_addr;
                if (!req_rd) begin
                    O_WDATA <= req_data;
                end
            end
            if (O_RD_STB) begin
                rd_core <= I_RDATA;
                ack_tgl <= ~ack_tgl;
            end
        end
    end
endmodule // i2c_slave_port

// ===== src/i2c_port_map.svh
`ifndef I2C_PORT_MAP_SVH
`define I2C_PORT_MAP_SVH

// Bus address and direction bit.
`define I2C_DEV_ADDR 7'h2e
`define I2C_DIR_WRITE 1'b0
`define I2C_DIR_READ 1'b1

// Bit positions within a byte transfer.
`define I2C_LAST_BIT 3'h7
`define I2C_ACK_SLOT 4'h8
`define I2C_FIFO_FLAG_BIT 7

// Reset values.
`define I2C_BYTE_RESET 8'h00
`define I2C_RDATA_RESET 8'hff
// The link-side reset lasts two to the power of this many core cycles after release.
`define I2C_RST_STRETCH_BIT 7

// Timing: core clock and the two serial clock periods.
`define I2C_CORE_CLK_NS 10
`define I2C_STD_PERIOD_NS 10000
`define I2C_FAST_PERIOD_NS 2500
// A quarter of the serial period in core cycles, rounded up so the rate never exceeds the limit.
`define I2C_STD_QUARTER \
    8'((`I2C_STD_PERIOD_NS + 4 * `I2C_CORE_CLK_NS - 1) / (4 * `I2C_CORE_CLK_NS))
`define I2C_FAST_QUARTER \
    8'((`I2C_FAST_PERIOD_NS + 4 * `I2C_CORE_CLK_NS - 1) / (4 * `I2C_CORE_CLK_NS))

`endif

// ===== src/i2c_port_pkg.sv
package i2c_port_pkg;

    typedef enum logic [2:0] {
        dev_idle,
        dev_recv,
        dev_ackwait,
        dev_ackhold,
        dev_tx,
        dev_txack,
        dev_txnext
    } dev_state_t;

    typedef enum logic [1:0] {
        kind_dev,
        kind_reg,
        kind_data
    } byte_kind_t;

    typedef enum logic [2:0] {
        mst_idle,
        mst_start,
        mst_tx,
        mst_rx,
        mst_stop
    } mst_state_t;

    typedef enum logic [1:0] {
        stage_devw,
        stage_reg,
        stage_data,
        stage_devr
    } mst_stage_t;

endpackage

// ===== src/i2c_link_if.sv
`timescale 1ns/1ns
interface i2c_link_if;
    logic scl_o;
    logic scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: a line is low only while an enabled driver pulls it low.
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport dev (
        input scl,
        input sda,
        output s_sda_o,
        output s_sda_oe
    );

    modport host (
        input scl,
        input sda,
        output scl_o,
        output scl_oe,
        output m_sda_o,
        output m_sda_oe
    );
endinterface

// ===== src/i2c_bus_master.sv
`timescale 1ns/1ns
`include "i2c_port_map.svh"
module i2c_bus_master (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic I_FAST,
    input wire logic I_CMD_VALID,
    output logic O_CMD_READY,
    input wire logic I_CMD_READ,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_COUNT,
    input wire logic [7:0] I_WDATA,
    output logic O_WDATA_TAKE,
    output logic [7:0] O_RDATA,
    output logic O_RDATA_VALID,
    output logic O_NACK,
    output logic O_BUSY,
    i2c_link_if.host LINK
);
    i2c_port_pkg::mst_state_t mstate;
    i2c_port_pkg::mst_stage_t stage;
    logic [7:0] qcnt;
    logic [7:0] qlim;
    logic tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] left;
    logic rd;
    logic [7:0] reg_addr;
    logic scl_low;
    logic sda_low;
    logic [2:0] sda_s;
    logic sda_f;

    // Both lines are only ever pulled low or released.
    assign LINK.scl_o = 1'b0;
    assign LINK.scl_oe = scl_low;
    assign LINK.m_sda_o = 1'b0;
    assign LINK.m_sda_oe = sda_low;
    assign O_CMD_READY = (mstate == i2c_port_pkg::mst_idle);
    assign O_BUSY = (mstate != i2c_port_pkg::mst_idle);

    assign qlim = I_FAST ? `I2C_FAST_QUARTER : `I2C_STD_QUARTER;
    assign tick = (qcnt == qlim - 8'h01);

    // The serial clock is this end's own divider, one quarter period per tick.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            qcnt <= 8'h00;
        end else if (I_CE) begin
            if (mstate == i2c_port_pkg::mst_idle || tick) begin
                qcnt <= 8'h00;
            end else begin
                qcnt <= qcnt + 8'h01;
            end
        end
    end

    // The data line is a pin: three stages, a change counts once the last two agree.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            sda_s <= 3'h7;
            sda_f <= 1'b1;
        end else if (I_CE) begin
            sda_s <= {sda_s[1:0], LINK.sda};
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            mstate <= i2c_port_pkg::mst_idle;
            stage <= i2c_port_pkg::stage_devw;
            q <= 2'h0;
            bitn <= 4'h0;
            sh <= `I2C_BYTE_RESET;
            left <= 8'h00;
            rd <= 1'b0;
            reg_addr <= `I2C_BYTE_RESET;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            O_WDATA_TAKE <= 1'b0;
            O_RDATA <= `I2C_BYTE_RESET;
            O_RDATA_VALID <= 1'b0;
            O_NACK <= 1'b0;
        end else if (I_CE) begin
            O_WDATA_TAKE <= 1'b0;
            O_RDATA_VALID <= 1'b0;
            if (mstate == i2c_port_pkg::mst_idle) begin
                q <= 2'h0;
                if (I_CMD_VALID) begin
                    mstate <= i2c_port_pkg::mst_start;
                    stage <= i2c_port_pkg::stage_devw;
                    rd <= I_CMD_READ;
                    reg_addr <= I_REG_ADDR;
                    left <= (I_CMD_READ && I_COUNT == 8'h00) ? 8'h01 : I_COUNT;
                    O_NACK <= 1'b0;
                end
            end else if (tick) begin
                q <= q + 2'h1;
                case (mstate)
                    i2c_port_pkg::mst_start: begin
                        // Falling data with the clock high marks the start. The clock rises a
                        // quarter late, since a slave may still be releasing its acknowledge.
                        if (q == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (q == 2'h2) begin
                            sda_low <= 1'b1;
                        end else if (q == 2'h3) begin
                            scl_low <= 1'b1;
                            mstate <= i2c_port_pkg::mst_tx;
                            bitn <= 4'h0;
                            sh <= (stage == i2c_port_pkg::stage_devr) ?
                                {`I2C_DEV_ADDR, `I2C_DIR_READ} :
                                {`I2C_DEV_ADDR, `I2C_DIR_WRITE};
                        end
                    end
                    i2c_port_pkg::mst_tx: begin
                        if (q == 2'h0) begin
                            // Data moves only in the low phase.
                            sda_low <= (bitn == `I2C_ACK_SLOT) ? 1'b0 : ~sh[7];
                        end else if (q == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (q == 2'h3) begin
                            scl_low <= 1'b1;
                            if (bitn != `I2C_ACK_SLOT) begin
                                sh <= {sh[6:0], 1'b0};
                                bitn <= bitn + 4'h1;
                            end else if (sda_f) begin
                                O_NACK <= 1'b1;
                                mstate <= i2c_port_pkg::mst_stop;
                            end else begin
                                bitn <= 4'h0;
                                case (stage)
                                    i2c_port_pkg::stage_devw: begin
                                        sh <= reg_addr;
                                        stage <= i2c_port_pkg::stage_reg;
                                    end
                                    i2c_port_pkg::stage_devr: begin
                                        mstate <= i2c_port_pkg::mst_rx;
                                    end
                                    default: begin
                                        if (rd) begin
                                            stage <= i2c_port_pkg::stage_devr;
                                            mstate <= i2c_port_pkg::mst_start;
                                        end else if (left == 8'h00) begin
                                            mstate <= i2c_port_pkg::mst_stop;
                                        end else begin
                                            sh <= I_WDATA;
                                            O_WDATA_TAKE <= 1'b1;
                                            left <= left - 8'h01;
                                            stage <= i2c_port_pkg::stage_data;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    i2c_port_pkg::mst_rx: begin
                        if (q == 2'h0) begin
                            // Acknowledge every byte but the last one.
                            sda_low <= (bitn == `I2C_ACK_SLOT) && (left != 8'h01);
                        end else if (q == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (q == 2'h3) begin
                            scl_low <= 1'b1;
                            if (bitn != `I2C_ACK_SLOT) begin
                                sh <= {sh[6:0], sda_f};
                                bitn <= bitn + 4'h1;
                            end else begin
                                O_RDATA <= sh;
                                O_RDATA_VALID <= 1'b1;
                                bitn <= 4'h0;
                                if (left == 8'h01) begin
                                    mstate <= i2c_port_pkg::mst_stop;
                                end else begin
                                    left <= left - 8'h01;
                                end
                            end
                        end
                    end
                    i2c_port_pkg::mst_stop: begin
                        // Rising data with the clock high marks the stop.
                        if (q == 2'h0) begin
                            sda_low <= 1'b1;
                        end else if (q == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (q == 2'h2) begin
                            sda_low <= 1'b0;
                        end else begin
                            mstate <= i2c_port_pkg::mst_idle;
                        end
                    end
                    default: begin
                        mstate <= i2c_port_pkg::mst_idle;
                    end
                endcase
            end
        end
    end
endmodule // i2c_bus_master

// ===== dv/i2c_link_checker.sv
`timescale 1ns/1ns
module i2c_link_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    logic scl_q, sda_q, first, foreign;
    logic [3:0] cnt;
    logic [7:0] byte0;
    logic [15:0] gap;
    wire rise = scl && !scl_q;
    wire start = scl && scl_q && sda_q && !sda;
    wire ack_slot = rise && cnt == 4'h8 && first;
    // Bits are counted on the resolved wires, because that is all a listener on the bus sees.
    always_ff @(posedge I_CORE_CLK) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || start) begin
            cnt <= 4'h0;
            first <= 1'b1;
        end else if (rise) begin
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            first <= first && cnt != 4'h8;
            byte0 <= (first && cnt != 4'h8) ? {byte0[6:0], sda} : byte0;
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || start) foreign <= 1'b0;
        else if (ack_slot && byte0[7:1] != 7'h2e) foreign <= 1'b1;
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || rise) gap <= 16'h0;
        else if (gap != 16'hffff) gap <= gap + 16'h1;
    end
    sequence s_start; scl && $past(scl) && $fell(sda); endsequence
    sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
    a_start_master: assert property (s_start |-> m_sda_oe) else $error("bad start");
    a_stop_clean: assert property (s_stop |-> !s_sda_oe && !$past(s_sda_oe))
        else $error("slave drove at stop");
    a_drain_only: assert property (!(s_sda_oe && s_sda_o) && !(m_sda_oe && m_sda_o))
        else $error("data line driven high");
    a_clock_master: assert property ($fell(scl) |-> scl_oe && !scl_o)
        else $error("clock not from master");
    a_slave_low: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl))
        else $error("slave changed data with clock high");
    a_master_off: assert property (rise && s_sda_oe |-> !m_sda_oe)
        else $error("master drove during slave slot");
    a_addr_ack: assert property (ack_slot && byte0[7:1] == 7'h2e |-> !sda && s_sda_oe)
        else $error("own address not acknowledged");
    a_foreign_off: assert property (foreign |-> !s_sda_oe) else $error("foreign drive");
    a_rate_limit: assert property (rise |-> gap >= 16'd249) else $error("clock too fast");
endmodule // i2c_link_checker

// ===== dv/i2c_slave_register_port_bench.sv
`timescale 1ns/1ns
module i2c_slave_register_port_bench;
    logic clk, lclk, rst, fast, accept, valid, rd, ready, take, rvalid, nack, busy, wstb, rstb;
    logic [7:0] addr, cnt, wdata, rdata, mrdata, saddr, swdata;
    logic [7:0] q_addr[$];
    logic [7:0] q_data[$];
    int fails = 0;
    int comparisons = 0;
    i2c_link_if link ();
    i2c_bus_master i2c_bus_master_i (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_FAST(fast),
        .I_CMD_VALID(valid), .O_CMD_READY(ready), .I_CMD_READ(rd), .I_REG_ADDR(addr),
        .I_COUNT(cnt), .I_WDATA(wdata), .O_WDATA_TAKE(take), .O_RDATA(mrdata),
        .O_RDATA_VALID(rvalid), .O_NACK(nack), .O_BUSY(busy), .LINK(link));
    i2c_slave_port i2c_slave_port_i (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1),
        .I_LINK_CLK(lclk), .I_ACCEPT(accept), .I_RDATA(rdata), .O_WR_STB(wstb),
        .O_RD_STB(rstb), .O_ADDR(saddr), .O_WDATA(swdata), .LINK(link));
    i2c_link_checker i2c_link_checker_i (.I_CORE_CLK(clk), .I_RESET(rst), .scl_o(link.scl_o),
        .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
        .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #37;
        forever #80 lclk = ~lclk;
    end
    // Read bytes advance only after the strobe's sampling edge, so each byte is predictable.
    always @(posedge clk) begin
        if (wstb || rstb) q_addr.push_back(saddr);
        if (wstb) q_data.push_back(swdata);
        if (rvalid) q_data.push_back(mrdata);
        if (rstb) rdata <= rdata + 8'h01;
        if (take) wdata <= wdata + 8'h11;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic xfer(input logic f, input logic r, input logic [7:0] a, input logic [7:0] c,
        input logic [7:0] d, input int n, input logic nk);
        int i;
        q_addr.delete();
        q_data.delete();
        @(posedge clk);
        fast <= f;
        valid <= 1'b1;
        rd <= r;
        addr <= a;
        cnt <= c;
        wdata <= d;
        rdata <= d;
        @(posedge clk);
        valid <= 1'b0;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (busy !== 1'b0 && i < 40000);
        if (i >= 40000) begin
            fails++;
            final_report();
        end
        chk("count", 8'(n), 8'(q_addr.size()));
        chk("data count", 8'(n), 8'(q_data.size()));
        for (i = 0; i < n; i++) begin
            chk("addr", a, q_addr[i]);
            chk("data", d + 8'(i) * (r ? 8'h01 : 8'h11), q_data[i]);
        end
        chk("nack", {7'h0, nk}, {7'h0, nack});
    endtask
    initial begin
        clk = 1'b0;
        lclk = 1'b0;
        rst = 1'b1;
        fast = 1'b0;
        accept = 1'b1;
        valid = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        cnt = 8'h00;
        wdata = 8'h00;
        rdata = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (60) @(posedge clk);
        xfer(1'b0, 1'b0, 8'h05, 8'h01, 8'h3c, 1, 1'b0);
        xfer(1'b1, 1'b0, 8'h81, 8'h03, 8'ha5, 3, 1'b0);
        xfer(1'b1, 1'b1, 8'h07, 8'h01, 8'h5a, 1, 1'b0);
        xfer(1'b1, 1'b1, 8'h82, 8'h03, 8'h10, 3, 1'b0);
        xfer(1'b1, 1'b0, 8'h06, 8'h02, 8'h21, 1, 1'b1);
        accept <= 1'b0;
        xfer(1'b1, 1'b0, 8'h83, 8'h01, 8'h44, 0, 1'b1);
        final_report();
    end
endmodule // i2c_slave_register_port_bench
